// [logic/psmp_fifo.sv]
module psmp_fifo #(
  parameter int WIDTH = psmp_pkg::REQ_W,
  parameter int DEPTH = psmp_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W:0] count;
  logic [PTR_W:0] next_count;
  logic push;
  logic pop;

  if (DEPTH < 2 || (1 << PTR_W) != DEPTH || WIDTH < 1) begin : g_bad_cfg
    $error("psmp_fifo: depth must be a power of two, at least 2");
  end

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + (PTR_W + 1)'(1);
    end else if (pop && !push) begin
      next_count = count - (PTR_W + 1)'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Flags are registered so both handshake outputs come from flops
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + PTR_W'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + PTR_W'(1);
      end
      count <= next_count;
      in_ready <= next_count != (PTR_W + 1)'(DEPTH);
      out_valid <= next_count != '0;
    end
  end

endmodule

// [logic/psmp_pkg.sv]
package psmp_pkg;

  // Data path and address widths of the wide instance
  localparam int DATA_W = 64;
  localparam int ADDR_W = 20;
  localparam int BE_W = 8;

  // Chip-select spaces
  localparam int SPACE_W = 2;
  localparam int NUM_SPACE = 4;

  // Latency fields and the edge counter that measures them
  localparam int LAT_W = 2;
  localparam int CNT_W = 3;

  // Request queue and pin synchroniser depth
  localparam int FIFO_DEPTH = 4;
  localparam int SYNC_STAGES = 3;

  // Selects of the two interface clocks
  localparam logic CLK_SEL_ONE = 1'h0;
  localparam logic CLK_SEL_TWO = 1'h1;

  // Per-space secondary control word
  typedef struct packed {
    logic sync_clock_select;
    logic strobe_read_enable_mode;
    logic chip_sel_extend;
    logic [LAT_W-1:0] write_latency_sel;
    logic [LAT_W-1:0] read_latency_sel;
  } psmp_cfg_t;

  localparam int CFG_W = $bits(psmp_cfg_t);
  localparam psmp_cfg_t CFG_RESET = psmp_cfg_t'(7'h00);

  // One queued access
  typedef struct packed {
    logic is_write;
    logic [SPACE_W-1:0] space;
    logic [ADDR_W-1:0] addr;
    logic [BE_W-1:0] be_n;
    logic [DATA_W-1:0] data;
  } psmp_req_t;

  localparam int REQ_W = $bits(psmp_req_t);

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_BUSY = 3'h2,
    ST_DESEL = 3'h4
  } psmp_state_t;

endpackage

// [logic/psmp_port.sv]
// Notes on behaviour
// - Read data sampled one to four cycles later
// - Write data driven zero to three cycles later
// - Extend off: chip select drops after command
// - Extend on: chip select follows output enable on reads; writes drop it after command
// - Mode off: address strobe with deselect cycles
// - Mode on: read enable, no deselect cycles
// - Interface timed from one of two clocks
// - Settings held separately per chip-select space
// - Shared strobes act as strobe, enables
module psmp_port #(
  parameter int NUM_SPACE = psmp_pkg::NUM_SPACE,
  parameter int FIFO_DEPTH = psmp_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Per-space secondary control write
  input wire logic cfg_wr,
  input wire logic [psmp_pkg::SPACE_W-1:0] cfg_space,
  input wire psmp_pkg::psmp_cfg_t cfg_data,
  // Per-space secondary control read back
  input wire logic [psmp_pkg::SPACE_W-1:0] cfg_rd_space,
  output psmp_pkg::psmp_cfg_t cfg_rd_data,
  // Access requests
  input wire logic req_valid,
  output logic req_ready,
  input wire psmp_pkg::psmp_req_t req,
  // Read return
  output logic rd_valid,
  output logic [psmp_pkg::DATA_W-1:0] rd_data,
  // Status
  output logic busy,
  output logic wr_done,
  // Interface clocks from outside
  input wire logic ext_clock_out_one,
  input wire logic ext_clock_out_two,
  // Memory pins, all strobes active low
  output logic [NUM_SPACE-1:0] chip_select_n,
  output logic [psmp_pkg::BE_W-1:0] byte_enable_n,
  output logic [psmp_pkg::ADDR_W-1:0] ext_address,
  input wire logic [psmp_pkg::DATA_W-1:0] ext_data_in,
  output logic [psmp_pkg::DATA_W-1:0] ext_data_out,
  output logic ext_data_oe,
  output logic addr_strobe_or_read_en_n,
  output logic sync_output_enable_n,
  output logic sync_write_enable_n
);

  if (NUM_SPACE != (1 << psmp_pkg::SPACE_W)) begin : g_bad_space
    $error("psmp_port: space count must match the space field");
  end
  if (FIFO_DEPTH < 2) begin : g_bad_depth
    $error("psmp_port: request queue too shallow");
  end

  psmp_pkg::psmp_cfg_t space_secondary_ctrl [NUM_SPACE];
  psmp_pkg::psmp_cfg_t head_cfg;
  psmp_pkg::psmp_cfg_t cur_cfg;
  psmp_pkg::psmp_cfg_t sel_cfg;
  psmp_pkg::psmp_req_t head;
  psmp_pkg::psmp_req_t cur;
  psmp_pkg::psmp_state_t state;
  psmp_pkg::psmp_state_t next_state;

  logic [psmp_pkg::REQ_W-1:0] head_bits;
  logic head_valid;
  logic [1:0] clk_lvl;
  logic [1:0] clk_prev;
  logic [1:0] clk_rise;
  logic [psmp_pkg::DATA_W-1:0] data_sync;
  logic [psmp_pkg::CNT_W-1:0] cnt;
  logic [psmp_pkg::CNT_W-1:0] lat_rd;
  logic [psmp_pkg::CNT_W-1:0] lat_wr;
  logic edge_now;
  logic start;
  logic in_busy;
  logic rd_last;
  logic wr_drive;
  logic wr_last;
  logic done;
  logic head_wl_zero;
  logic [psmp_pkg::CNT_W-1:0] prime_cnt;
  logic primed;
  logic [1:0] clk_armed;

  // Settings, one word per space, written independently
  for (genvar s = 0; s < NUM_SPACE; s++) begin : g_space
    always_ff @(posedge mclk) begin
      if (sys_rst) begin
        space_secondary_ctrl[s] <= psmp_pkg::CFG_RESET;
      end else if (cfg_wr && cfg_space == psmp_pkg::SPACE_W'(s)) begin
        space_secondary_ctrl[s] <= cfg_data;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cfg_rd_data <= psmp_pkg::CFG_RESET;
    end else begin
      cfg_rd_data <= space_secondary_ctrl[cfg_rd_space];
    end
  end

  // Requests wait here; the engine pops only on an interface edge
  psmp_fifo #(
    .WIDTH(psmp_pkg::REQ_W),
    .DEPTH(FIFO_DEPTH)
  ) u_queue (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .in_valid(req_valid),
    .in_ready(req_ready),
    .in_data(req),
    .out_valid(head_valid),
    .out_ready(start),
    .out_data(head_bits)
  );

  assign head = psmp_pkg::psmp_req_t'(head_bits);
  assign head_cfg = space_secondary_ctrl[head.space];

  // Clocks and read data share the same synchroniser depth so that
  // the data seen at a detected rise is the data of that rise
  psmp_sync #(
    .WIDTH(2)
  ) u_clk_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .async_in({ext_clock_out_two, ext_clock_out_one}),
    .stable_out(clk_lvl)
  );

  psmp_sync #(
    .WIDTH(psmp_pkg::DATA_W)
  ) u_data_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .async_in(ext_data_in),
    .stable_out(data_sync)
  );

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      clk_prev <= 2'h0;
    end else begin
      clk_prev <= clk_lvl;
    end
  end

  assign primed = prime_cnt == psmp_pkg::CNT_W'(psmp_pkg::SYNC_STAGES + 1);

  // A free-running clock may be high as reset ends, and the settled
  // level starts low; a rise counts only once the level was seen low
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      prime_cnt <= '0;
      clk_armed <= 2'h0;
    end else begin
      if (!primed) begin
        prime_cnt <= prime_cnt + psmp_pkg::CNT_W'(1);
      end else begin
        clk_armed <= clk_armed | ~clk_lvl;
      end
    end
  end

  assign clk_rise = clk_lvl & ~clk_prev & clk_armed;

  // Idle follows the waiting request's space; an access keeps its own
  assign sel_cfg = (state == psmp_pkg::ST_IDLE) ? head_cfg : cur_cfg;
  assign edge_now = (sel_cfg.sync_clock_select == psmp_pkg::CLK_SEL_TWO)
                    ? clk_rise[1] : clk_rise[0];

  assign start = (state == psmp_pkg::ST_IDLE) && edge_now && head_valid;
  assign in_busy = (state == psmp_pkg::ST_BUSY) && edge_now;

  assign lat_rd = {1'b0, cur_cfg.read_latency_sel} + psmp_pkg::CNT_W'(1);
  assign lat_wr = {1'b0, cur_cfg.write_latency_sel};
  assign rd_last = !cur.is_write && cnt == lat_rd;
  assign wr_drive = cur.is_write && cnt == lat_wr;
  assign wr_last = cur.is_write && cnt == lat_wr + psmp_pkg::CNT_W'(1);
  assign done = rd_last || wr_last;
  assign head_wl_zero = head_cfg.write_latency_sel == '0;

  always_comb begin
    next_state = state;
    unique case (state)
      psmp_pkg::ST_IDLE: begin
        if (start) begin
          next_state = psmp_pkg::ST_BUSY;
        end
      end
      psmp_pkg::ST_BUSY: begin
        if (in_busy && done) begin
          if (cur_cfg.strobe_read_enable_mode) begin
            next_state = psmp_pkg::ST_IDLE;
          end else begin
            next_state = psmp_pkg::ST_DESEL;
          end
        end
      end
      psmp_pkg::ST_DESEL: begin
        if (edge_now) begin
          next_state = psmp_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = psmp_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state <= psmp_pkg::ST_IDLE;
      busy <= 1'b0;
    end else begin
      state <= next_state;
      busy <= next_state != psmp_pkg::ST_IDLE;
    end
  end

  // Settings are latched so a write mid-access cannot bend its timing
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cur <= psmp_pkg::psmp_req_t'('0);
      cur_cfg <= psmp_pkg::CFG_RESET;
      cnt <= '0;
    end else if (start) begin
      cur <= head;
      cur_cfg <= head_cfg;
      cnt <= psmp_pkg::CNT_W'(1);
    end else if (in_busy) begin
      cnt <= cnt + psmp_pkg::CNT_W'(1);
    end
  end

  // Command, address and strobes
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      chip_select_n <= '1;
      byte_enable_n <= '1;
      ext_address <= '0;
      addr_strobe_or_read_en_n <= 1'b1;
      sync_output_enable_n <= 1'b1;
      sync_write_enable_n <= 1'b1;
    end else if (start) begin
      chip_select_n <= ~(NUM_SPACE'(1) << head.space);
      byte_enable_n <= head.be_n;
      ext_address <= head.addr;
      addr_strobe_or_read_en_n <= 1'b0;
      sync_write_enable_n <= ~head.is_write;
      sync_output_enable_n <= head.is_write;
    end else if (in_busy) begin
      addr_strobe_or_read_en_n <= 1'b1;
      sync_write_enable_n <= 1'b1;
      if (cur.is_write || !cur_cfg.chip_sel_extend) begin
        chip_select_n <= '1;
      end
      if (rd_last) begin
        sync_output_enable_n <= 1'b1;
        chip_select_n <= '1;
      end
      if (done && !cur_cfg.strobe_read_enable_mode) begin
        // Deselect command: strobe low with every select high
        addr_strobe_or_read_en_n <= 1'b0;
        chip_select_n <= '1;
      end
    end else if (state == psmp_pkg::ST_DESEL && edge_now) begin
      addr_strobe_or_read_en_n <= 1'b1;
    end
  end

  // Write data, driven for one interface cycle
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ext_data_out <= '0;
      ext_data_oe <= 1'b0;
      wr_done <= 1'b0;
    end else begin
      wr_done <= in_busy && wr_last;
      if (start && head.is_write && head_wl_zero) begin
        ext_data_out <= head.data;
        ext_data_oe <= 1'b1;
      end else if (in_busy && wr_drive) begin
        ext_data_out <= cur.data;
        ext_data_oe <= 1'b1;
      end else if (in_busy && wr_last) begin
        ext_data_oe <= 1'b0;
      end
    end
  end

  // Read data taken at the rise that ends the latency
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rd_valid <= 1'b0;
      rd_data <= '0;
    end else begin
      rd_valid <= in_busy && rd_last;
      if (in_busy && rd_last) begin
        rd_data <= data_sync;
      end
    end
  end

endmodule

// [logic/psmp_sync.sv]
module psmp_sync #(
  parameter int WIDTH = 1,
  parameter int STAGES = psmp_pkg::SYNC_STAGES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Foreign-domain input and its settled level
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] stable_out
);

  logic [WIDTH-1:0] stage_one;
  logic [WIDTH-1:0] stage_two;
  logic [WIDTH-1:0] stage_three;
  logic [WIDTH-1:0] agree;

  if (WIDTH < 1 || STAGES != 3) begin : g_bad_cfg
    $error("psmp_sync: unsupported width or depth");
  end

  // Stage one feeds only stage two
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      stage_one <= '0;
      stage_two <= '0;
      stage_three <= '0;
    end else begin
      stage_one <= async_in;
      stage_two <= stage_one;
      stage_three <= stage_two;
    end
  end

  assign agree = ~(stage_two ^ stage_three);

  // A change counts once the later two stages agree
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      stable_out <= '0;
    end else begin
      stable_out <= (stable_out & ~agree) | (stage_three & agree);
    end
  end

endmodule

// [testbench/psmp_mem_model.sv]
module psmp_mem_model (
  // Interface clocks and latency
  input wire logic clk_one,
  input wire logic clk_two,
  input wire logic clk_sel,
  input wire logic [1:0] lat,
  // Memory pins
  input wire logic [3:0] cs_n,
  input wire logic [19:0] addr,
  input wire logic [63:0] wdata,
  input wire logic oe,
  input wire logic ads_n,
  input wire logic soe_n,
  input wire logic swe_n,
  output logic [63:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] mem [16];
  logic [3:0] ra = 4'h0;
  logic [3:0] wa = 4'h0;
  int n = 9;
  wire logic ck = clk_sel ? clk_two : clk_one;
  // Data stands for one edge only; otherwise the inverse is shown
  always @(posedge ck) begin
    n = n + 1;
    if (!ads_n && !(&cs_n) && !swe_n)
      wa = addr[3:0];
    if (!ads_n && !(&cs_n) && !soe_n) begin
      ra = addr[3:0];
      n = 0;
    end
    if (oe)
      mem[wa] = wdata;
    rdata = (n == int'(lat)) ? mem[ra] : ~mem[ra];
  end
endmodule

// [testbench/psmp_port_chk.sv]
module psmp_port_chk #(
  parameter int NUM_SPACE = 4
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Interface clock pins
  input wire logic ext_clock_out_one,
  input wire logic ext_clock_out_two,
  // Status
  input wire logic rd_valid,
  input wire logic busy,
  input wire logic wr_done,
  // Memory pins
  input wire logic [NUM_SPACE-1:0] chip_select_n,
  input wire logic ext_data_oe,
  input wire logic addr_strobe_or_read_en_n,
  input wire logic sync_output_enable_n,
  input wire logic sync_write_enable_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  property p_rdv;
    $rose(sync_output_enable_n) |-> rd_valid;
  endproperty
  a_rdv: assert property (p_rdv)
    else $error("read return missing");
  property p_rdp;
    rd_valid |-> sync_output_enable_n
      && !$past(sync_output_enable_n);
  endproperty
  a_rdp: assert property (p_rdp)
    else $error("read return without read");
  property p_wrd;
    $fell(ext_data_oe) |-> ##[0:1] wr_done;
  endproperty
  a_wrd: assert property (p_wrd)
    else $error("write completion missing");
  property p_oe;
    ext_data_oe |-> sync_output_enable_n && busy;
  endproperty
  a_oe: assert property (p_oe)
    else $error("data driven outside write");
  property p_idle;
    !busy && !$past(busy) |-> &chip_select_n;
  endproperty
  a_idle: assert property (p_idle)
    else $error("select active while idle");
  property p_swe;
    $fell(sync_write_enable_n) |-> !addr_strobe_or_read_en_n
      && !(&chip_select_n) && sync_output_enable_n;
  endproperty
  a_swe: assert property (p_swe)
    else $error("write command malformed");
  property p_soe;
    $fell(sync_output_enable_n) |-> !addr_strobe_or_read_en_n
      && sync_write_enable_n;
  endproperty
  a_soe: assert property (p_soe)
    else $error("read command malformed");
  property p_pace;
    $changed(chip_select_n) |->
      ($past(ext_clock_out_one, 5) && !$past(ext_clock_out_one, 6))
      || ($past(ext_clock_out_two, 5) && !$past(ext_clock_out_two, 6));
  endproperty
  a_pace: assert property (p_pace)
    else $error("select moved off interface edge");
endmodule

bind psmp_port psmp_port_chk #(.NUM_SPACE(NUM_SPACE)) psmp_port_chk_inst (
  .mclk, .sys_rst, .ext_clock_out_one, .ext_clock_out_two,
  .rd_valid, .busy, .wr_done, .chip_select_n,
  .ext_data_oe, .addr_strobe_or_read_en_n, .sync_output_enable_n,
  .sync_write_enable_n
);

// [testbench/psmp_port_tb_top.sv]
module psmp_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'h0;
  logic sys_rst = 1'h1;
  logic ck1 = 1'h0;
  logic ck2 = 1'h0;
  logic csel = 1'h0;
  logic [1:0] mlat = 2'h0;
  logic cfg_wr = 1'h0;
  logic req_valid = 1'h0;
  logic [1:0] cfg_space = 2'h0;
  logic [1:0] rd_sp = 2'h0;
  psmp_pkg::psmp_cfg_t cfg_data = '0;
  psmp_pkg::psmp_cfg_t rd_cfg;
  psmp_pkg::psmp_cfg_t cf [4];
  psmp_pkg::psmp_req_t req = '0;
  logic req_ready, rd_valid, busy, wr_done, oe, ads_n, soe_n, swe_n;
  logic [63:0] rd_data, din, dout;
  logic [19:0] addr;
  logic [3:0] cs_n;
  logic [7:0] be_n;
  int num_errors = 0;
  int tests_run = 0;
  int desel = 0;

  always #5 mclk = ~mclk;
  // Free-running link clocks, rising away from system edges
  always #62.5 ck1 = ~ck1;
  always #100 ck2 = ~ck2;

  always @(posedge mclk)
    if (!sys_rst && !ads_n && &cs_n)
      desel <= desel + 1;

  psmp_port psmp_port_inst (
    .mclk, .sys_rst, .cfg_wr, .cfg_space, .cfg_data,
    .cfg_rd_space(rd_sp), .cfg_rd_data(rd_cfg), .req_valid,
    .req_ready, .req, .rd_valid, .rd_data, .busy, .wr_done,
    .ext_clock_out_one(ck1), .ext_clock_out_two(ck2),
    .chip_select_n(cs_n), .byte_enable_n(be_n), .ext_address(addr),
    .ext_data_in(din), .ext_data_out(dout), .ext_data_oe(oe),
    .addr_strobe_or_read_en_n(ads_n), .sync_output_enable_n(soe_n),
    .sync_write_enable_n(swe_n)
  );

  psmp_mem_model psmp_mem_model_inst (
    .clk_one(ck1), .clk_two(ck2), .clk_sel(csel), .lat(mlat),
    .cs_n, .addr, .wdata(dout), .oe, .ads_n, .soe_n, .swe_n,
    .rdata(din)
  );

  task chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  task give_verdict;
    $display("tests_run %0d num_errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task set_cfg(input int s, input psmp_pkg::psmp_cfg_t c);
    @(posedge mclk);
    cfg_space <= s[1:0];
    cfg_data <= c;
    cfg_wr <= 1'h1;
    @(posedge mclk);
    cfg_wr <= 1'h0;
  endtask

  task access(input logic w, input int s, input logic [63:0] d,
              input logic x);
    int n;
    @(posedge mclk);
    req <= '{w, s[1:0], {16'h0, d[3:0]}, d[63:56], d};
    req_valid <= 1'h1;
    for (n = 0; n < 600; n++) begin
      @(posedge mclk);
      req_valid <= 1'h0;
      #1;
      if (x && !soe_n)
        chk(cs_n[s], 0);
      if ((w ? wr_done : rd_valid) === 1'h1)
        break;
    end
    if (n == 600) begin
      num_errors++;
      give_verdict;
    end
    chk(be_n, d[63:56]);
    if (!w)
      chk(rd_data, d);
  endtask

  task t_cfg;
    cf[0] = 7'h00;
    cf[1] = 7'h36;
    cf[2] = 7'h4d;
    cf[3] = 7'h23;
    for (int i = 0; i < 4; i++)
      set_cfg(i, cf[i]);
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      rd_sp <= i[1:0];
      repeat (2) @(posedge mclk);
      #1;
      chk(rd_cfg, cf[i]);
    end
    $display("settings test done");
  endtask

  task t_lat;
    int d0;
    for (int l = 0; l < 4; l++) begin
      set_cfg(0, {3'h0, l[1:0], l[1:0]});
      mlat <= l[1:0];
      d0 = desel;
      access(1'h1, 0, 64'h1111_0000_0000_0000 + l, 1'h0);
      access(1'h0, 0, 64'h1111_0000_0000_0000 + l, 1'h0);
      chk(desel > d0, 1);
    end
    $display("latency test done");
  endtask

  task t_fifo;
    int d0;
    repeat (30) @(posedge mclk);
    mlat <= 2'h2;
    d0 = desel;
    access(1'h1, 1, 64'h2222_0000_0000_0005, 1'h0);
    access(1'h0, 1, 64'h2222_0000_0000_0005, 1'h1);
    chk(desel, d0);
    $display("fifo mode test done");
  endtask

  task t_clk2;
    csel <= 1'h1;
    mlat <= 2'h1;
    access(1'h1, 2, 64'h3333_0000_0000_0009, 1'h0);
    access(1'h0, 2, 64'h3333_0000_0000_0009, 1'h0);
    csel <= 1'h0;
    $display("second clock test done");
  endtask

  task t_full;
    int k;
    int m;
    int n;
    bit full;
    k = 0;
    m = 0;
    full = 0;
    mlat <= 2'h3;
    @(posedge mclk);
    req <= '{1'h1, 2'h3, 20'h0000c, 8'h00, 64'h4444};
    req_valid <= 1'h1;
    for (n = 0; n < 9; n++) begin
      #1;
      if (req_ready === 1'h1)
        k++;
      else
        full = 1;
      @(posedge mclk);
    end
    req_valid <= 1'h0;
    chk(full, 1);
    for (n = 0; n < 3000 && m < k; n++) begin
      @(posedge mclk);
      #1;
      if (wr_done === 1'h1)
        m++;
    end
    chk(m, k);
    chk(req_ready, 1);
    $display("queue test done");
  endtask

  initial begin
    repeat (10) @(posedge mclk);
    sys_rst <= 1'h0;
    repeat (4) @(posedge mclk);
    #1;
    chk({cs_n, ads_n, soe_n, swe_n, oe, req_ready, busy}, 64'h3fa);
    t_cfg;
    t_lat;
    t_fifo;
    t_clk2;
    t_full;
    give_verdict;
  end
endmodule
